// *** testbench/sms_mcu_model.sv ***
// Controller model driving the register port
`timescale 1ns/100ps
module sms_mcu_model (
  // Clock
  input wire logic CORE_CLK,
  // Register port
  output logic [7:0] ADDR,
  output logic [15:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [15:0] RDATA
);
  // Idle bus from time zero
  initial begin
    ADDR = 8'h00;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Write; flipped data on release catch stale values
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    WDATA <= ~d;
    @(posedge CORE_CLK);
  endtask : wr
  // Read; data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
endmodule : sms_mcu_model

// *** testbench/sms_mode_fsm_checker.sv ***
// Port assertions for the mode state machine
`timescale 1ns/100ps
`include "sms_params.svh"
module sms_mode_fsm_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  // Pin and watchdog
  input wire logic INT_OE,
  input wire logic INT_WEAK,
  input wire logic WD_FAIL,
  input wire logic WD_LONG_WINDOW,
  input wire logic [2:0] WD_PERIOD,
  // System outputs
  input wire logic RESET_OUT_N,
  input wire logic FAIL_ACTIVE,
  input wire logic [2:0] MODE_STATE,
  input wire logic SECOND_SUPPLY_EN,
  input wire logic [3:0] HIGH_SIDE_EN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // Reset output and mode transitions
  property p_restart_ro; $rose(MODE_STATE == 3'h5) |=> !RESET_OUT_N [*8]; endproperty
  a_restart_ro: assert property (p_restart_ro) else $error("reset out high in restart");
  property p_powerup_ro; MODE_STATE == 3'h0 |-> !RESET_OUT_N; endproperty
  a_powerup_ro: assert property (p_powerup_ro) else $error("reset out high at power-up");
  property p_ro_release; $rose(RESET_OUT_N) |-> ##[0:1] (MODE_STATE == 3'h1 || MODE_STATE == 3'h2); endproperty
  a_ro_release: assert property (p_ro_release) else $error("reset released in wrong mode");
  property p_long_window; $rose(RESET_OUT_N) |-> ##[0:2] WD_LONG_WINDOW; endproperty
  a_long_window: assert property (p_long_window) else $error("no long window at release");
  property p_restart_exit;
    $fell(MODE_STATE == 3'h5) && MODE_STATE == 3'h2 |->
      ##[0:1] (WD_PERIOD == `SMS_WD_PERIOD_DEFAULT && HIGH_SIDE_EN == 4'h0 && !SECOND_SUPPLY_EN);
  endproperty
  a_restart_exit: assert property (p_restart_exit) else $error("restart exit defaults wrong");
  property p_init_any; MODE_STATE == 3'h1 && (RD || (WR && ADDR != `SMS_ADDR_MODE)) && !WD_FAIL |=> MODE_STATE == 3'h2;
  endproperty
  a_init_any: assert property (p_init_any) else $error("access in init did not reach normal");
  property p_stop_freeze; MODE_STATE == 3'h3 && WR && ADDR == `SMS_ADDR_SUPPLY && !WD_FAIL |=>
    ##1 $stable(SECOND_SUPPLY_EN) && $stable(HIGH_SIDE_EN); endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("supply changed in stop");
  property p_stop_sleep; MODE_STATE == 3'h3 && WR && ADDR == `SMS_ADDR_MODE && WDATA[2:0] == `SMS_MODE_SLEEP
    && !WD_FAIL |=> MODE_STATE == 3'h5; endproperty
  a_stop_sleep: assert property (p_stop_sleep) else $error("sleep from stop not restart");
  property p_wd_fail; WD_FAIL && (MODE_STATE == 3'h2 || MODE_STATE == 3'h3) |=>
    (MODE_STATE == 3'h5 || MODE_STATE == 3'h6); endproperty
  a_wd_fail: assert property (p_wd_fail) else $error("watchdog failure ignored");
  property p_fail_keep; FAIL_ACTIVE && MODE_STATE != 3'h2 |=> FAIL_ACTIVE; endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("fail outputs dropped");
  property p_init_quiet; MODE_STATE == 3'h1 && $past(MODE_STATE) == 3'h1 |-> !(INT_OE && !INT_WEAK); endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("interrupt in init");
  // Main scenarios reached
  c_wd: cover property (WD_FAIL && MODE_STATE == 3'h2);
  c_stop: cover property ($rose(MODE_STATE == 3'h3));
  c_exit: cover property ($fell(MODE_STATE == 3'h5));
endmodule : sms_mode_fsm_checker

bind sms_mode_fsm sms_mode_fsm_checker u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .INT_OE(INT_OE), .INT_WEAK(INT_WEAK), .WD_FAIL(WD_FAIL), .WD_LONG_WINDOW(WD_LONG_WINDOW),
  .WD_PERIOD(WD_PERIOD), .RESET_OUT_N(RESET_OUT_N), .FAIL_ACTIVE(FAIL_ACTIVE), .MODE_STATE(MODE_STATE),
  .SECOND_SUPPLY_EN(SECOND_SUPPLY_EN), .HIGH_SIDE_EN(HIGH_SIDE_EN));

// *** testbench/testbench.sv ***
// Self-checking bench of the mode state machine
`timescale 1ns/100ps
`include "sms_params.svh"
module testbench;
  import sms_pkg::*;
  logic CORE_CLK = 1'b0, NRST = 1'b0, lclk = 1'b0, pu = 1'b1, MAIN_SUPPLY_OK = 1'b0, MAIN_SUPPLY_OV = 1'b0;
  logic WAKE_CAN = 1'b0, WD_FAIL = 1'b0, FAILSAFE_EXIT = 1'b0, FAIL_TEST_PIN_IN = 1'b1;
  logic [7:0] ADDR;
  logic [15:0] WDATA, RDATA, rv, rv2;
  logic WR, RD, INT_OUT, INT_OE, INT_WEAK, INT_IN, RESET_OUT_N, FAIL_ACTIVE, SECOND_SUPPLY_EN;
  logic [2:0] MODE_STATE, WD_PERIOD;
  logic [3:0] HIGH_SIDE_EN;
  int n_fail = 0, compares = 0, exp_mode = 0, exp_fail = 0, wd_cnt = 0, csel = 0;
  // Clocks; the wake side runs on its own unrelated clock
  always #2.5 CORE_CLK = ~CORE_CLK;
  always #32 lclk = ~lclk;
  // Strong drive beats the strap resistor, which beats the weak pull-down
  assign INT_IN = (INT_OE && !INT_WEAK) ? INT_OUT : pu;
  sms_mode_fsm u_sms_mode_fsm (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .INT_IN(INT_IN), .INT_OUT(INT_OUT), .INT_OE(INT_OE), .INT_WEAK(INT_WEAK),
    .FAIL_TEST_PIN_IN(FAIL_TEST_PIN_IN), .MAIN_SUPPLY_OK(MAIN_SUPPLY_OK), .MAIN_SUPPLY_OV(MAIN_SUPPLY_OV),
    .WAKE_CAN(WAKE_CAN), .WAKE_LIN(1'b0), .WAKE_PINS(3'h0), .WD_FAIL(WD_FAIL), .SLEEP_WAKE(1'b0),
    .FAILSAFE_EXIT(FAILSAFE_EXIT), .WD_LONG_WINDOW(), .WD_REFRESH(), .WD_DISABLE(), .WD_PERIOD(WD_PERIOD),
    .RESET_OUT_N(RESET_OUT_N), .FAIL_ACTIVE(FAIL_ACTIVE), .MODE_STATE(MODE_STATE),
    .SECOND_SUPPLY_EN(SECOND_SUPPLY_EN), .HIGH_SIDE_EN(HIGH_SIDE_EN));
  sms_mcu_model u_sms_mcu_model (.CORE_CLK(CORE_CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA));

  task finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task chk_mode;
    compares++;
    if (MODE_STATE !== 3'(exp_mode)) begin
      n_fail++;
      $display("mismatch t=%0t mode=%h exp=%h", $time, MODE_STATE, 3'(exp_mode));
    end
  endtask : chk_mode
  // Bounded wait for the reset output to release
  task wait_ro;
    int i;
    for (i = 0; i < 3000 && RESET_OUT_N !== 1'b1; i++) @(posedge CORE_CLK);
    if (i == 3000) begin
      n_fail++;
      finish_test();
    end
    @(posedge CORE_CLK);
    #1;
  endtask : wait_ro
  task wait_int;
    int i;
    for (i = 0; i < 20 && !(INT_OE === 1'b1 && INT_WEAK === 1'b0); i++) @(posedge CORE_CLK);
    chk_val({15'h0, INT_OE && !INT_WEAK}, 16'h1);
  endtask : wait_int
  // Power cycle with a given strap, then first access
  task power_up(input logic strap);
    @(posedge CORE_CLK);
    NRST <= 1'b0;
    MAIN_SUPPLY_OK <= 1'b0;
    pu <= strap;
    repeat (2) @(posedge CORE_CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    #1 chk_val({15'h0, RESET_OUT_N}, 16'h0);
    MAIN_SUPPLY_OK <= 1'b1;
    wd_cnt = 0;
    exp_fail = 0;
    wait_ro();
    exp_mode = 1;
    chk_mode();
    u_sms_mcu_model.rd(`SMS_ADDR_WAKE_LVL, rv2);
    chk_val(rv2 & 16'h3, {14'h0, !FAIL_TEST_PIN_IN, strap});
    exp_mode = 2;
    chk_mode();
  endtask : power_up
  // Watchdog failure against the configuration model
  task wd_fail;
    @(posedge CORE_CLK);
    WD_FAIL <= 1'b1;
    @(posedge CORE_CLK);
    WD_FAIL <= 1'b0;
    wd_cnt++;
    if (csel == 1 || wd_cnt >= 2) exp_fail = 1;
    exp_mode = (pu == 1'b0 && (csel == 1 || wd_cnt >= 2)) ? 6 : 5;
    repeat (2) @(posedge CORE_CLK);
    #1 chk_mode();
    chk_val({15'h0, FAIL_ACTIVE}, 16'(exp_fail));
  endtask : wd_fail
  task ov_event(input logic en);
    @(posedge CORE_CLK);
    MAIN_SUPPLY_OV <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    MAIN_SUPPLY_OV <= 1'b0;
    if (en) begin
      exp_fail = 1;
      exp_mode = pu ? 5 : 6;
    end
    #1 chk_mode();
    chk_val({15'h0, FAIL_ACTIVE}, 16'(exp_fail));
    u_sms_mcu_model.rd(`SMS_ADDR_DEVSTAT, rv2);
    chk_val({15'h0, rv2[2]}, 16'h1);
  endtask : ov_event

  // Main sequence
  initial begin
    void'($urandom(68154));
    power_up(1'b1);
    rv = 16'($urandom) & 16'h001f;
    u_sms_mcu_model.wr(`SMS_ADDR_SUPPLY, rv);
    #1 chk_val({11'h0, HIGH_SIDE_EN, SECOND_SUPPLY_EN}, rv);
    u_sms_mcu_model.wr(`SMS_ADDR_HWCTRL, 16'h0000);
    csel = 0;
    ov_event(1'b0);
    @(posedge lclk);
    WAKE_CAN <= 1'b1;
    wait_int();
    chk_mode();
    repeat (500) @(posedge CORE_CLK);
    u_sms_mcu_model.wr(`SMS_ADDR_MODE, {13'h0, `SMS_MODE_STOP});
    #1 exp_mode = 3;
    chk_mode();
    wait_int();
    u_sms_mcu_model.wr(`SMS_ADDR_SUPPLY, ~rv & 16'h001f);
    #1 chk_val({11'h0, HIGH_SIDE_EN, SECOND_SUPPLY_EN}, rv);
    u_sms_mcu_model.rd(`SMS_ADDR_DEVSTAT, rv2);
    chk_val({15'h0, rv2[1]}, 16'h1);
    u_sms_mcu_model.wr(`SMS_ADDR_MODE, {13'h0, `SMS_MODE_SLEEP});
    #1 exp_mode = 5;
    chk_mode();
    wait_ro();
    exp_mode = 2;
    chk_mode();
    u_sms_mcu_model.rd(`SMS_ADDR_MODE, rv2);
    chk_val(rv2 & 16'h0007, 16'h0);
    chk_val({8'h0, WD_PERIOD, HIGH_SIDE_EN, SECOND_SUPPLY_EN}, {8'h0, 3'h4, 5'h0});
    wd_fail();
    wait_ro();
    wd_fail();
    wait_ro();
    u_sms_mcu_model.wr(`SMS_ADDR_HWCTRL, 16'h0002);
    ov_event(1'b1);
    wait_ro();
    power_up(1'b0);
    u_sms_mcu_model.wr(`SMS_ADDR_HWCTRL, 16'h0001);
    csel = 1;
    wd_fail();
    @(posedge CORE_CLK);
    FAILSAFE_EXIT <= 1'b1;
    @(posedge CORE_CLK);
    FAILSAFE_EXIT <= 1'b0;
    #1 exp_mode = 5;
    chk_mode();
    wait_ro();
    power_up(1'b0);
    u_sms_mcu_model.wr(`SMS_ADDR_HWCTRL, 16'h0002);
    ov_event(1'b1);
    finish_test();
  end
endmodule : testbench

// *** verilog/sms_mode_fsm.sv ***
// Operating-mode state machine with strap capture, fail outputs and register port
//
// Notes on behaviour
// RL1 - Mode field write selects the operating mode
// RL2 - Mode field cleared while passing Restart
// RL3 - Power-on enters Init, long window starts
// RL4 - Weak pull-down, filter, strap latched at release
// RL5 - Power-on flag set re-arms strap capture
// RL6 - Unstable strap level latches as zero
// RL7 - Strap high: watchdog failure goes Restart
// RL8 - Strap low: failure goes Fail-Safe per count
// RL9 - Overvoltage, enable, strap high: fail, Restart
// RL10 - Overvoltage, enable, strap low: fail, Fail-Safe
// RL11 - Overvoltage without enable only sets flag
// RL12 - Count-select and strap readable by software
// RL13 - Latched strap holds until power loss
// RL14 - Test pin at power-up selects development mode
// RL15 - Any access in Init enters Normal
// RL16 - Missed long window means failure, Restart
// RL17 - Wake events dropped in Init
// RL18 - Power-up holds reset, suppresses flags
// RL19 - Wake in Normal/Stop pulses interrupt only
// RL20 - Normal entry from Restart: outputs off, failures kept
// RL21 - Fail test bit works in Normal only
// RL22 - Stop refuses most writes, sets serial fail
// RL23 - Stop freezes settings made in Normal
// RL24 - Stop entry with pending wake raises interrupt
// RL25 - Sleep from Stop: serial fail, Restart
// RL26 - Wake measure excludes first two wake pins
// RL27 - Restart holds reset for delay, then Normal
// RL28 - Restart exit restarts window, period default
// RL29 - Sleep, Restart, Fail-Safe states exposed
`timescale 1ns/100ps
`include "sms_params.svh"

module sms_mode_fsm
  import sms_pkg::*;
(
  // Clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Interrupt / strap pin
  input wire logic INT_IN,
  output logic INT_OUT,
  output logic INT_OE,
  output logic INT_WEAK,
  // Pins and analog flags from outside the clock domain
  input wire logic FAIL_TEST_PIN_IN,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic MAIN_SUPPLY_OV,
  input wire logic WAKE_CAN,
  input wire logic WAKE_LIN,
  input wire logic [2:0] WAKE_PINS,
  // Watchdog and mode blocks on the same clock
  input wire logic WD_FAIL,
  input wire logic SLEEP_WAKE,
  input wire logic FAILSAFE_EXIT,
  output logic WD_LONG_WINDOW,
  output logic WD_REFRESH,
  output logic WD_DISABLE,
  output logic [2:0] WD_PERIOD,
  // Outputs to the system
  output logic RESET_OUT_N,
  output logic FAIL_ACTIVE,
  output logic [2:0] MODE_STATE,
  output logic SECOND_SUPPLY_EN,
  output logic [3:0] HIGH_SIDE_EN
);

  localparam int unsigned DELAY_CYC = `SMS_RESET_DELAY_CYC;
  localparam int unsigned FILT_CYC = `SMS_CFG_FILTER_CYC;
  localparam int unsigned PULSE_CYC = `SMS_INT_PULSE_CYC;

  sms_state_e state;
  sms_state_e next_state;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic ov_prev;
  logic [4:0] wake_prev;
  logic [11:0] delay_cnt;
  logic [7:0] filt_cnt;
  logic filt_stable;
  logic filt_level;
  logic [8:0] int_cnt;
  logic strap;
  logic devmode;
  logic [2:0] mode_field;
  logic count_sel;
  logic ov_rst_en;
  logic fail_test;
  logic wake_meas;
  logic [2:0] wake_a;
  logic [1:0] wake_b;
  logic por_flag;
  logic serial_fail;
  logic ov_flag;
  logic uv_flag;
  logic [1:0] wd_cnt;
  logic fail_latched;
  logic second_en;
  logic [3:0] hs_en;
  logic [2:0] wd_period;

  // Synchronised copies of outside signals; only sync2 is read by logic
  logic int_s;
  logic fotest_s;
  logic supply_ok_s;
  logic ov_s;
  logic [4:0] wake_s;
  assign int_s = sync2[0];
  assign fotest_s = sync2[1];
  assign supply_ok_s = sync2[2];
  assign ov_s = sync2[3];
  assign wake_s = sync2[8:4];

  // Sticky flag update: a set in the same cycle as its clear wins
  function automatic logic [2:0] sticky(input logic [2:0] cur, input logic [2:0] set, input logic [2:0] clr);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // Decoded events
  logic live;
  logic cfg_ok;
  logic bus_any;
  logic wr_cfg;
  logic wr_stop;
  logic mode_wr;
  logic [2:0] mode_val;
  logic wd_evt;
  logic ov_evt;
  logic [4:0] wake_edge;
  logic [4:0] wake_src;
  logic in_delay;
  logic delay_done;
  logic ro_rise;
  logic fail_set;
  logic stop_refused;
  logic stop_entry_irq;
  logic wake_irq;
  sms_state_e wd_target;

  assign live = (state == SMS_INIT) || (state == SMS_NORMAL) || (state == SMS_STOP);
  assign cfg_ok = (state == SMS_INIT) || (state == SMS_NORMAL);
  assign bus_any = (WR || RD) && live;
  assign wr_cfg = WR && cfg_ok;
  assign wr_stop = WR && (state == SMS_STOP);
  assign mode_wr = WR && live && (ADDR == `SMS_ADDR_MODE);
  assign mode_val = WDATA[2:0];
  assign wd_evt = WD_FAIL && live && !devmode; // see RL16
  assign ov_evt = ov_s && !ov_prev;
  assign wake_edge = wake_s & ~wake_prev;
  assign wake_src = wake_edge & {1'b1, ~{2{wake_meas}}, 2'b11}; // see RL26
  assign in_delay = (state == SMS_POWERUP) || (state == SMS_RESTART);
  assign delay_done = (delay_cnt == 12'(DELAY_CYC - 1)) && supply_ok_s; // see RL18
  assign ro_rise = in_delay && (next_state != state);
  // Strap high always restarts; strap low fails safe unless first failure with count-select 0
  assign wd_target = (strap || (!count_sel && wd_cnt == 2'h0)) ? SMS_RESTART : SMS_FAILSAFE; // see RL7 see RL8
  assign fail_set = (wd_evt && (count_sel || wd_cnt != 2'h0)) || (ov_evt && ov_rst_en && live); // see RL9 see RL10
  assign stop_refused = wr_stop && !(ADDR == `SMS_ADDR_MODE || ADDR == `SMS_ADDR_WDCTRL
    || ADDR == `SMS_ADDR_WAKE_A || ADDR == `SMS_ADDR_WAKE_B || ADDR == `SMS_ADDR_DEVSTAT); // see RL22
  assign stop_entry_irq = (state != SMS_STOP) && (next_state == SMS_STOP) && ((wake_a != 3'h0) || (wake_b != 2'h0));
  assign wake_irq = ((state == SMS_NORMAL) || (state == SMS_STOP)) && (wake_src != 5'h0); // see RL19

  // Two-flop synchronisers for pins and analog flags
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {WAKE_PINS, WAKE_LIN, WAKE_CAN, MAIN_SUPPLY_OV, MAIN_SUPPLY_OK, FAIL_TEST_PIN_IN, INT_IN};
      sync2 <= sync1;
    end
  end

  // Edge history of synchronised flags
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ov_prev <= 1'b0;
      wake_prev <= 5'h00;
    end else begin
      ov_prev <= ov_s;
      wake_prev <= wake_s;
    end
  end

  // Next mode; supply loss outranks overvoltage, which outranks watchdog and software
  always_comb begin
    next_state = state;
    case (state)
      SMS_POWERUP: begin
        if (delay_done) begin
          next_state = SMS_INIT; // see RL3
        end
      end
      SMS_INIT, SMS_NORMAL, SMS_STOP: begin
        if (!supply_ok_s) begin
          next_state = SMS_RESTART;
        end else if (ov_evt && ov_rst_en) begin
          next_state = strap ? SMS_RESTART : SMS_FAILSAFE; // see RL9 see RL10 see RL11
        end else if (wd_evt) begin
          next_state = wd_target; // see RL16
        end else if (state == SMS_INIT) begin
          if (bus_any) begin
            next_state = SMS_NORMAL; // see RL15
          end
        end else if (mode_wr && mode_val == `SMS_MODE_SOFT_RESET) begin
          next_state = SMS_INIT;
        end else if (mode_wr && state == SMS_NORMAL) begin
          if (mode_val == `SMS_MODE_SLEEP) begin
            next_state = SMS_SLEEP; // see RL1
          end else if (mode_val == `SMS_MODE_STOP) begin
            next_state = SMS_STOP;
          end
        end else if (mode_wr) begin
          if (mode_val == `SMS_MODE_NORMAL) begin
            next_state = SMS_NORMAL;
          end else if (mode_val == `SMS_MODE_SLEEP) begin
            next_state = SMS_RESTART; // see RL25
          end
        end
      end
      SMS_SLEEP: begin
        if (SLEEP_WAKE) begin
          next_state = SMS_RESTART; // see RL29
        end
      end
      SMS_RESTART: begin
        if (delay_done) begin
          next_state = SMS_NORMAL; // see RL27
        end
      end
      SMS_FAILSAFE: begin
        if (FAILSAFE_EXIT) begin
          next_state = SMS_RESTART;
        end
      end
      default: next_state = SMS_POWERUP;
    endcase
  end

  // Mode register and exposed state code
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= SMS_POWERUP;
      MODE_STATE <= 3'h0;
    end else begin
      state <= next_state;
      MODE_STATE <= 3'(next_state); // see RL29
    end
  end

  // Reset delay counter restarts on every mode change
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      delay_cnt <= 12'h000;
    end else if (!in_delay || next_state != state || !supply_ok_s) begin
      delay_cnt <= 12'h000;
    end else if (!delay_done) begin
      delay_cnt <= delay_cnt + 12'h001;
    end
  end

  // Reset output low during power-up and Restart
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RESET_OUT_N <= 1'b0;
    end else begin
      RESET_OUT_N <= !((next_state == SMS_POWERUP) || (next_state == SMS_RESTART)); // see RL18 see RL27
    end
  end

  // Strap level filter, counting only in the delay phases; any change restarts the stability count
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      filt_cnt <= 8'h00;
      filt_stable <= 1'b0;
      filt_level <= 1'b0;
    end else if (!in_delay || int_s != filt_level) begin
      filt_cnt <= 8'h00;
      filt_stable <= 1'b0;
      filt_level <= int_s;
    end else if (filt_cnt == 8'(FILT_CYC - 1)) begin
      filt_stable <= 1'b1; // see RL4
    end else begin
      filt_cnt <= filt_cnt + 8'h01;
    end
  end

  // Strap capture at the reset release, development mode at the power-up release only; only while power-on flag stands
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      strap <= 1'b0;
      devmode <= 1'b0;
    end else if (ro_rise && por_flag) begin
      strap <= filt_stable ? filt_level : 1'b0; // see RL5 see RL6 see RL13
      if (state == SMS_POWERUP) begin
        devmode <= !fotest_s; // see RL14
      end
    end
  end

  // Interrupt pulse timer; a new event restarts the pulse
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      int_cnt <= 9'h000;
    end else if (wake_irq || stop_entry_irq) begin
      int_cnt <= 9'(PULSE_CYC); // see RL24
    end else if (int_cnt != 9'h000) begin
      int_cnt <= int_cnt - 9'h001;
    end
  end

  // Interrupt pin drive; weak pull-down only during the delay phase with power-on flag set
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      INT_OUT <= 1'b0;
      INT_OE <= 1'b0;
      INT_WEAK <= 1'b0;
    end else begin
      INT_OUT <= 1'b0;
      INT_OE <= (in_delay && por_flag && supply_ok_s) || (int_cnt != 9'h000); // see RL4 see RL5
      INT_WEAK <= (int_cnt == 9'h000);
    end
  end

  // Mode field follows accepted writes, reads as Normal after Restart
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_field <= `SMS_MODE_NORMAL;
    end else if (state == SMS_RESTART) begin
      mode_field <= `SMS_MODE_NORMAL; // see RL2
    end else if (mode_wr && mode_val != `SMS_MODE_SOFT_RESET && state != SMS_INIT) begin
      mode_field <= mode_val; // see RL1
    end
  end

  // Hardware control; written only in Init and Normal, fail test bit cleared in delay phases and Fail-Safe
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      count_sel <= 1'b0;
      ov_rst_en <= 1'b0;
      fail_test <= 1'b0;
      wake_meas <= 1'b0;
    end else if (wr_cfg && ADDR == `SMS_ADDR_HWCTRL) begin
      count_sel <= WDATA[`SMS_HW_COUNT_SEL];
      ov_rst_en <= WDATA[`SMS_HW_OV_RST_EN];
      fail_test <= WDATA[`SMS_HW_FAIL_TEST] && (state == SMS_NORMAL); // see RL21 see RL23
      wake_meas <= WDATA[`SMS_HW_WAKE_MEAS];
    end else if (in_delay || state == SMS_FAILSAFE) begin
      fail_test <= 1'b0;
    end
  end

  // Second supply and high-side enables, off after Restart
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      second_en <= 1'b0;
      hs_en <= 4'h0;
    end else if (state == SMS_RESTART) begin
      second_en <= 1'b0; // see RL20
      hs_en <= 4'h0;
    end else if (wr_cfg && ADDR == `SMS_ADDR_SUPPLY) begin
      second_en <= WDATA[`SMS_SUP_SECOND];
      hs_en <= WDATA[`SMS_SUP_HS +: 4];
    end
  end

  // Watchdog period; a write in Stop only refreshes
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wd_period <= `SMS_WD_PERIOD_DEFAULT;
    end else if (state == SMS_RESTART) begin
      wd_period <= `SMS_WD_PERIOD_DEFAULT; // see RL28
    end else if (wr_cfg && ADDR == `SMS_ADDR_WDCTRL) begin
      wd_period <= WDATA[2:0];
    end
  end

  // Wake flags, cleared by writing ones; dropped in Init
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wake_a <= 3'h0;
      wake_b <= 2'h0;
    end else begin
      wake_a <= sticky(wake_a, wake_irq ? wake_src[4:2] : 3'h0, // see RL17
        (WR && live && ADDR == `SMS_ADDR_WAKE_A) ? WDATA[2:0] : 3'h0);
      wake_b <= 2'(sticky({1'b0, wake_b}, wake_irq ? {1'b0, wake_src[1:0]} : 3'h0,
        (WR && live && ADDR == `SMS_ADDR_WAKE_B) ? {1'b0, WDATA[1:0]} : 3'h0));
    end
  end

  // Device status flags
  logic dev_clr;
  assign dev_clr = WR && live && (ADDR == `SMS_ADDR_DEVSTAT);
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      por_flag <= 1'b1;
      serial_fail <= 1'b0;
      ov_flag <= 1'b0;
      uv_flag <= 1'b0;
      wd_cnt <= 2'h0;
    end else begin
      por_flag <= por_flag && !(dev_clr && WDATA[`SMS_ST_POR]);
      serial_fail <= stop_refused || (mode_wr && state == SMS_STOP && mode_val == `SMS_MODE_SLEEP) // see RL22 see RL25
        || (serial_fail && !(dev_clr && WDATA[`SMS_ST_SERIAL_FAIL]));
      ov_flag <= (ov_evt && live) || (ov_flag && !(dev_clr && WDATA[`SMS_ST_OV])); // see RL11
      uv_flag <= (!supply_ok_s && state != SMS_POWERUP) || (uv_flag && !(dev_clr && WDATA[`SMS_ST_UV])); // see RL18
      if (wd_evt && wd_cnt != 2'h3) begin
        wd_cnt <= wd_cnt + 2'h1;
      end else if (dev_clr && WDATA[`SMS_ST_WD_CNT +: 2] != 2'h0) begin
        wd_cnt <= 2'h0;
      end
    end
  end

  // Failure-driven fail outputs; only power loss clears them
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      fail_latched <= 1'b0;
    end else if (fail_set) begin
      fail_latched <= 1'b1; // see RL7 see RL8
    end
  end

  // Output stage
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      FAIL_ACTIVE <= 1'b0;
      SECOND_SUPPLY_EN <= 1'b0;
      HIGH_SIDE_EN <= 4'h0;
      WD_PERIOD <= `SMS_WD_PERIOD_DEFAULT;
      WD_DISABLE <= 1'b0;
      WD_LONG_WINDOW <= 1'b0;
      WD_REFRESH <= 1'b0;
    end else begin
      FAIL_ACTIVE <= fail_latched || fail_test; // see RL20 see RL21
      SECOND_SUPPLY_EN <= second_en;
      HIGH_SIDE_EN <= hs_en;
      WD_PERIOD <= wd_period;
      WD_DISABLE <= devmode;
      WD_LONG_WINDOW <= ro_rise || (live && next_state == SMS_INIT && state != SMS_INIT); // see RL3 see RL28
      WD_REFRESH <= WR && live && (ADDR == `SMS_ADDR_WDCTRL); // see RL15
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
    end else if (!RD) begin
      RDATA <= 16'h0000;
    end else begin
      case (ADDR)
        `SMS_ADDR_MODE: RDATA <= {13'h0000, mode_field};
        `SMS_ADDR_HWCTRL: RDATA <= {12'h000, wake_meas, fail_test, ov_rst_en, count_sel}; // see RL12
        `SMS_ADDR_WAKE_A: RDATA <= {13'h0000, wake_a};
        `SMS_ADDR_WAKE_B: RDATA <= {14'h0000, wake_b};
        `SMS_ADDR_WAKE_LVL: RDATA <= {9'h000, wake_s, devmode, strap}; // see RL12
        `SMS_ADDR_DEVSTAT: RDATA <= {10'h000, wd_cnt, uv_flag, ov_flag, serial_fail, por_flag};
        `SMS_ADDR_WDCTRL: RDATA <= {13'h0000, wd_period};
        `SMS_ADDR_SUPPLY: RDATA <= {11'h000, hs_en, second_en};
        default: RDATA <= 16'h0000;
      endcase
    end
  end

endmodule : sms_mode_fsm

// *** verilog/sms_params.svh ***
// Offsets, field positions, reset values and timing counts of the mode state machine
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// Register byte offsets
`define SMS_ADDR_MODE 8'h00
`define SMS_ADDR_HWCTRL 8'h04
`define SMS_ADDR_WAKE_A 8'h08
`define SMS_ADDR_WAKE_B 8'h0c
`define SMS_ADDR_WAKE_LVL 8'h10
`define SMS_ADDR_DEVSTAT 8'h14
`define SMS_ADDR_WDCTRL 8'h18
`define SMS_ADDR_SUPPLY 8'h1c

// Mode field codes
`define SMS_MODE_NORMAL 3'h0
`define SMS_MODE_SLEEP 3'h1
`define SMS_MODE_STOP 3'h2
`define SMS_MODE_SOFT_RESET 3'h3

// Hardware control bits
`define SMS_HW_COUNT_SEL 0
`define SMS_HW_OV_RST_EN 1
`define SMS_HW_FAIL_TEST 2
`define SMS_HW_WAKE_MEAS 3

// Device status bits
`define SMS_ST_POR 0
`define SMS_ST_SERIAL_FAIL 1
`define SMS_ST_OV 2
`define SMS_ST_UV 3
`define SMS_ST_WD_CNT 4

// Wake level status bits
`define SMS_LV_STRAP 0
`define SMS_LV_DEVMODE 1
`define SMS_LV_WAKE 2

// Supply control bits
`define SMS_SUP_SECOND 0
`define SMS_SUP_HS 1

// Reset values
`define SMS_WD_PERIOD_DEFAULT 3'h4

// Timing
`define SMS_CLK_PERIOD_NS 5
`define SMS_RESET_DELAY_NS 10000
`define SMS_RESET_DELAY_CYC ((`SMS_RESET_DELAY_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)
`define SMS_CFG_FILTER_NS 1000
`define SMS_CFG_FILTER_CYC ((`SMS_CFG_FILTER_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)
`define SMS_INT_PULSE_NS 2000
`define SMS_INT_PULSE_CYC ((`SMS_INT_PULSE_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)

`endif

// *** verilog/sms_pkg.sv ***
// Types of the mode state machine
package sms_pkg;
  typedef enum logic [2:0] {
    SMS_POWERUP,
    SMS_INIT,
    SMS_NORMAL,
    SMS_STOP,
    SMS_SLEEP,
    SMS_RESTART,
    SMS_FAILSAFE
  } sms_state_e;
endpackage : sms_pkg
